//--- rtl/ldrb_bank.sv
// Byte-wide register bank of the lighting director.
`include "ldrb_defs.svh"
`default_nettype none
module ldrb_bank #(
   parameter logic [7:0] DEV_TYPE = 8'hA5, // Arbitrary value.
   parameter logic [7:0] HW_REV = 8'h5A, // Arbitrary value.
   parameter logic [15:0] FW_MAJOR = 16'h0001, // Arbitrary value.
   parameter logic [15:0] FW_PATCH = 16'h0002, // Arbitrary value.
   parameter logic [15:0] FW_BUILD = 16'h0003, // Arbitrary value.
   parameter int STEP_CYC = `LDRB_STEP_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire ldrb_pkg::ldrb_acc_t acc,
   output logic [7:0] rdata,
   input wire ldrb_pkg::ldrb_res_t res,
   input wire logic conv_done,
   input wire logic gain_fault,
   input wire logic [7:0] die_temp,
   input wire logic [7:0] ext_status,
   output logic [1:0] gain_sel,
   output logic [7:0] exposure,
   output logic integ_tick,
   output logic soft_reset_busy,
   output logic learn_pulse,
   output logic [3:0] channel_mode_select,
   output logic [15:0] lux_goal,
   output logic conv_start,
   output logic int_out,
   output logic indicator_lamp_output
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0] ptr_r, ptr_nxt;
   logic [1:0] fwpos_r, fwpos_nxt;
   logic [1:0] gain_r, gain_nxt;
   logic rdy_r, rdy_nxt;
   logic soft_rst_r, soft_rst_nxt;
   logic [4:0] srcnt_r, srcnt_nxt;
   logic [7:0] expo_r, expo_nxt;
   logic [7:0] lamp_r, lamp_nxt;
   logic [3:0] mode_r, mode_nxt;
   logic inten_r, inten_nxt;
   logic learn_r, learn_nxt;
   logic start_r, start_nxt;
   logic [15:0] ch1_r, ch1_nxt, ch2_r, ch2_nxt, ch3_r, ch3_nxt;
   logic [15:0] lux_r, lux_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [21:0] tick_r, tick_nxt;
   ldrb_pkg::ldrb_st_t st_r, st_nxt;
   logic [7:0] a;
   logic wr, rd;
   logic [15:0] fwval;

   // Current access address: explicit on start, else the running pointer.
   assign a = acc.start ? acc.addr : ptr_r;
   assign wr = acc.wr;
   assign rd = acc.rd;

   // Firmware field selected by the stored position, zero when invalid.
   always_comb begin
      case (fwpos_r)
         `LDRB_FWPOS_MAJOR: fwval = FW_MAJOR;
         `LDRB_FWPOS_PATCH: fwval = FW_PATCH;
         `LDRB_FWPOS_BUILD: fwval = FW_BUILD;
         default: fwval = 16'h0000;
      endcase
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // Next-state logic for all host-visible registers.
   always_comb begin
      ptr_nxt = ptr_r;
      fwpos_nxt = fwpos_r;
      gain_nxt = gain_r;
      rdy_nxt = rdy_r;
      soft_rst_nxt = soft_rst_r;
      srcnt_nxt = srcnt_r;
      expo_nxt = expo_r;
      lamp_nxt = lamp_r;
      mode_nxt = mode_r;
      inten_nxt = inten_r;
      learn_nxt = 1'b0;
      start_nxt = start_r;
      ch1_nxt = ch1_r;
      ch2_nxt = ch2_r;
      ch3_nxt = ch3_r;
      lux_nxt = lux_r;
      rdata_nxt = rdata_r;
      st_nxt = st_r;
      tick_nxt = tick_r;
      // Integration period counter; a whole step per exposure unit.
      if (tick_r >= 22'(STEP_CYC - 1)) begin
         tick_nxt = 22'h000000;
      end else begin
         tick_nxt = tick_r + 22'h000001;
      end
      // Soft reset sequencer; the bit stays set until the count runs out.
      case (st_r)
         ldrb_pkg::LDRB_IDLE: begin
         end
         ldrb_pkg::LDRB_RESET: begin
            if (srcnt_r == 5'(`LDRB_SOFT_RST_CYC - 1)) begin
               soft_rst_nxt = 1'b0;
               st_nxt = ldrb_pkg::LDRB_IDLE;
            end else begin
               srcnt_nxt = srcnt_r + 5'h01;
            end
         end
         default: st_nxt = ldrb_pkg::LDRB_IDLE;
      endcase
      // Results latch when the director delivers; start clears then.
      if (res.valid) begin
         ch1_nxt = res.ch1;
         ch2_nxt = (mode_r == 4'h0) ? 16'h0000 : res.ch2;
         ch3_nxt = (mode_r == 4'h0) ? 16'h0000 :
                   (mode_r == 4'h1) ? ~res.ch2 : res.ch3;
         start_nxt = 1'b0;
      end
      if (wr) begin
         ptr_nxt = a + 8'h01;
         case (a)
            `LDRB_A_FWHI, `LDRB_A_FWLO: begin
               // Out-of-range codes fall back to the zero field.
               fwpos_nxt = (acc.wdata >= 8'h01 && acc.wdata <= 8'h03) ?
                           acc.wdata[1:0] : 2'h0;
            end
            `LDRB_A_SETUP: begin
               gain_nxt = acc.wdata[`LDRB_B_GAIN_HI:`LDRB_B_GAIN_LO];
               if (acc.wdata[`LDRB_B_SOFT_RST] || acc.wdata[`LDRB_B_FAULT_RST]) begin
                  soft_rst_nxt = 1'b1;
                  srcnt_nxt = 5'h00;
                  st_nxt = ldrb_pkg::LDRB_RESET;
               end
            end
            `LDRB_A_EXPO: expo_nxt = acc.wdata;
            `LDRB_A_LAMP: lamp_nxt = acc.wdata;
            `LDRB_A_DIRSET: begin
               mode_nxt = acc.wdata[`LDRB_B_MODE_HI:`LDRB_B_MODE_LO];
               inten_nxt = acc.wdata[`LDRB_B_INTEN];
               learn_nxt = acc.wdata[`LDRB_B_LEARN];
            end
            `LDRB_A_DIRHS: begin
               if (acc.wdata[`LDRB_B_START]) begin
                  start_nxt = 1'b1;
               end
            end
            `LDRB_A_LUXH: lux_nxt[15:8] = acc.wdata;
            `LDRB_A_LUXL: lux_nxt[7:0] = acc.wdata;
            default: begin
            end
         endcase
      end else if (rd) begin
         ptr_nxt = a + 8'h01;
         case (a)
            `LDRB_A_DEVTYPE: rdata_nxt = DEV_TYPE;
            `LDRB_A_HWREV: rdata_nxt = HW_REV;
            `LDRB_A_FWHI: rdata_nxt = fwval[15:8];
            `LDRB_A_FWLO: rdata_nxt = fwval[7:0];
            `LDRB_A_SETUP: begin
               rdata_nxt = {gain_fault, 1'b0, gain_r, 2'h0, rdy_r, soft_rst_r};
               rdy_nxt = 1'b0;
            end
            `LDRB_A_EXPO: rdata_nxt = expo_r;
            `LDRB_A_TEMP: rdata_nxt = die_temp;
            `LDRB_A_LAMP: rdata_nxt = lamp_r;
            `LDRB_A_EXTDEV: rdata_nxt = ext_status;
            `LDRB_A_DIRSET: rdata_nxt = {mode_r, 2'h0, inten_r, learn_r};
            `LDRB_A_DIRHS: rdata_nxt = {7'h00, start_r};
            `LDRB_A_CH1H: rdata_nxt = ch1_r[15:8];
            `LDRB_A_CH1L: rdata_nxt = ch1_r[7:0];
            `LDRB_A_CH2H: rdata_nxt = ch2_r[15:8];
            `LDRB_A_CH2L: rdata_nxt = ch2_r[7:0];
            `LDRB_A_CH3H: rdata_nxt = ch3_r[15:8];
            `LDRB_A_CH3L: rdata_nxt = ch3_r[7:0];
            `LDRB_A_LUXH: rdata_nxt = lux_r[15:8];
            `LDRB_A_LUXL: rdata_nxt = lux_r[7:0];
            default: rdata_nxt = 8'h00;
         endcase
      end else if (acc.start) begin
         ptr_nxt = acc.addr;
      end
      // A new conversion wins over a same-cycle clearing read.
      if (conv_done) begin
         rdy_nxt = 1'b1;
      end
   end

   // ****************************************************************
   // Register stage
   // ****************************************************************

   // Register stage; everything takes a constant under reset.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ptr_r <= 8'h00;
         fwpos_r <= 2'h0;
         gain_r <= 2'h0;
         rdy_r <= 1'b0;
         soft_rst_r <= 1'b0;
         srcnt_r <= 5'h00;
         expo_r <= `LDRB_RST_EXPO;
         lamp_r <= `LDRB_RST_LAMP;
         mode_r <= 4'h0;
         inten_r <= 1'b0;
         learn_r <= 1'b0;
         start_r <= 1'b0;
         ch1_r <= 16'h0000;
         ch2_r <= 16'h0000;
         ch3_r <= 16'h0000;
         lux_r <= 16'h0000;
         rdata_r <= 8'h00;
         tick_r <= 22'h000000;
         st_r <= ldrb_pkg::LDRB_IDLE;
      end else begin
         ptr_r <= ptr_nxt;
         fwpos_r <= fwpos_nxt;
         gain_r <= gain_nxt;
         rdy_r <= rdy_nxt;
         soft_rst_r <= soft_rst_nxt;
         srcnt_r <= srcnt_nxt;
         expo_r <= expo_nxt;
         lamp_r <= lamp_nxt;
         mode_r <= mode_nxt;
         inten_r <= inten_nxt;
         learn_r <= learn_nxt;
         start_r <= start_nxt;
         ch1_r <= ch1_nxt;
         ch2_r <= ch2_nxt;
         ch3_r <= ch3_nxt;
         lux_r <= lux_nxt;
         rdata_r <= rdata_nxt;
         tick_r <= tick_nxt;
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdata = rdata_r;
   assign gain_sel = gain_r;
   assign exposure = expo_r;
   assign integ_tick = (tick_r == 22'h000000);
   assign soft_reset_busy = soft_rst_r;
   assign learn_pulse = learn_r;
   assign channel_mode_select = mode_r;
   assign lux_goal = lux_r;
   assign conv_start = start_r;
   // Interrupt is gated; the flag itself remains pollable.
   assign int_out = rdy_r & inten_r;
   assign indicator_lamp_output = lamp_r[0];

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // ****************************************************************
   // Checks: identity and firmware readout
   // ****************************************************************
   // Read checks leave out cycles with a write, since the write side wins then.
   id_read_a: assert property (
      (rd && !wr && a == `LDRB_A_DEVTYPE) |=> (rdata == DEV_TYPE))
      else $error("Device type byte wrong.");
   rev_read_a: assert property (
      (rd && !wr && a == `LDRB_A_HWREV) |=> (rdata == HW_REV))
      else $error("Revision byte wrong.");
   fw_invalid_zero_a: assert property (
      (wr && (a == `LDRB_A_FWHI || a == `LDRB_A_FWLO) &&
       (acc.wdata > 8'h03 || acc.wdata == 8'h00)) |=> (fwpos_r == 2'h0))
      else $error("Invalid firmware position did not zero.");
   fw_select_a: assert property (
      (wr && (a == `LDRB_A_FWHI || a == `LDRB_A_FWLO) &&
       acc.wdata >= 8'h01 && acc.wdata <= 8'h03)
      |=> (fwpos_r == $past(acc.wdata[1:0])))
      else $error("Firmware position not taken.");
   fw_major_a: assert property (
      (rd && !wr && a == `LDRB_A_FWHI && fwpos_r == `LDRB_FWPOS_MAJOR)
      |=> (rdata == FW_MAJOR[15:8]))
      else $error("Major version high byte wrong.");
   fw_build_a: assert property (
      (rd && !wr && a == `LDRB_A_FWLO && fwpos_r == `LDRB_FWPOS_BUILD)
      |=> (rdata == FW_BUILD[7:0]))
      else $error("Build version low byte wrong.");

   // ****************************************************************
   // Checks: sensor setup
   // ****************************************************************
   gain_write_a: assert property (
      (wr && a == `LDRB_A_SETUP)
      |=> (gain_sel == $past(acc.wdata[`LDRB_B_GAIN_HI:`LDRB_B_GAIN_LO])))
      else $error("Gain field not taken.");
   setup_rsvd_a: assert property (
      (rd && !wr && a == `LDRB_A_SETUP) |=> (rdata[6] == 1'b0 && rdata[3:2] == 2'h0))
      else $error("Reserved setup bits not zero.");
   ready_sets_a: assert property (
      conv_done |=> rdy_r)
      else $error("Ready flag not set by conversion.");
   ready_read_clear_a: assert property (
      (rd && a == `LDRB_A_SETUP && !conv_done) |=> !rdy_r)
      else $error("Ready flag not cleared by read.");
   // The enable is left out while it is being rewritten in the same cycle.
   int_gate_a: assert property (
      (conv_done && inten_r && !(wr && a == `LDRB_A_DIRSET)) |=> int_out)
      else $error("Interrupt gating wrong.");
   fault_reset_a: assert property (
      (wr && a == `LDRB_A_SETUP && acc.wdata[`LDRB_B_FAULT_RST]) |=> soft_reset_busy)
      else $error("Fault bit write did not start a soft reset.");
   // Sixteen busy cycles sit inside the window: eight counted, then up to twenty more.
   soft_done_a: assert property (
      $rose(soft_rst_r) |-> soft_rst_r [*8] ##[1:20] !soft_rst_r)
      else $error("Soft reset bit did not self-clear.");
   expo_write_a: assert property (
      (wr && a == `LDRB_A_EXPO) |=> (exposure == $past(acc.wdata)))
      else $error("Integration time not taken.");
   temp_read_a: assert property (
      (rd && !wr && a == `LDRB_A_TEMP) |=> (rdata == $past(die_temp)))
      else $error("Temperature byte wrong.");
   ext_read_a: assert property (
      (rd && !wr && a == `LDRB_A_EXTDEV) |=> (rdata == $past(ext_status)))
      else $error("External status byte wrong.");
   lamp_write_a: assert property (
      (wr && a == `LDRB_A_LAMP) |=> (indicator_lamp_output == $past(acc.wdata[0])))
      else $error("Indicator enable not taken.");

   // ****************************************************************
   // Checks: director and pointer
   // ****************************************************************
   mode_write_a: assert property (
      (wr && a == `LDRB_A_DIRSET)
      |=> (channel_mode_select == $past(acc.wdata[`LDRB_B_MODE_HI:`LDRB_B_MODE_LO])))
      else $error("Channel mode not taken.");
   learn_clear_a: assert property (
      (learn_r && !(wr && a == `LDRB_A_DIRSET && acc.wdata[`LDRB_B_LEARN])) |=> !learn_r)
      else $error("Learn bit did not clear.");
   start_set_a: assert property (
      (wr && a == `LDRB_A_DIRHS && acc.wdata[`LDRB_B_START]) |=> conv_start)
      else $error("Start request not taken.");
   // A start written in the same cycle as the results is kept for the next run.
   start_clear_a: assert property (
      (res.valid && !(wr && a == `LDRB_A_DIRHS)) |=> !start_r)
      else $error("Start not cleared on results.");
   ch1_latch_a: assert property (
      res.valid |=> (ch1_r == $past(res.ch1)))
      else $error("Channel one result not latched.");
   mode0_zero_a: assert property (
      (res.valid && mode_r == 4'h0) |=> (ch2_r == 16'h0000 && ch3_r == 16'h0000))
      else $error("Mode 0 channels not zero.");
   mode1_comp_a: assert property (
      (res.valid && mode_r == 4'h1) |=> (ch3_r == ~$past(res.ch2)))
      else $error("Mode 1 channel three not the complement.");
   lux_write_a: assert property (
      (wr && a == `LDRB_A_LUXL) |=> (lux_goal[7:0] == $past(acc.wdata)))
      else $error("Lux target low byte not taken.");
   ptr_inc_a: assert property (
      (rd || wr) |=> (ptr_r == $past(a) + 8'h01))
      else $error("Pointer did not advance.");

   // ****************************************************************
   // Cover points
   // ****************************************************************
   cov_soft_c: cover property ($fell(soft_rst_r));
   cov_int_c: cover property ($rose(int_out));
   cov_result_c: cover property (start_r ##[1:50] res.valid);
   cov_learn_c: cover property (learn_r);
   cov_mode1_c: cover property (res.valid && mode_r == 4'h1);

endmodule
`default_nettype wire

//--- rtl/ldrb_defs.svh
// Register offsets, field positions, reset values and timing counts of the register bank.
//
// How it works
// - Two read-only identity bytes at 0x00/0x01.
// - Writing 1-3 selects the firmware field shown.
// - Other firmware position writes make both read zero.
// - Codes 1..3 show major, patch, build halves.
// - Bit 7 reads gain fault; writing one resets.
// - Gain field bits 5:4 resets to 00.
// - Ready flag bit 1 drives interrupt if enabled.
// - Ready flag clears on setup read or reset.
// - Soft reset bit 0 self-clears when complete.
// - Integration time value times 2.8 ms, resets 20.
// - Temperature register is read-only degrees Celsius.
// - External device register is read-only status.
// - Channel mode bits 7:4 pick director mode.
// - Director setup bit 1 enables interrupt pin.
// - Learn bit 0 self-clears after being set.
// - Start bit clears when PWM results ready.
// - Channel results are read-only 16-bit pairs.
// - Channel one carries dimming or brightness value.
// - Channel two zero in mode 0.
// - Channel three zero in mode 0, complement mode 1.
// - Lux target 16-bit read-write pair, resets zero.
// - Register pointer advances after each data byte.
`ifndef LDRB_DEFS_SVH
`define LDRB_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LDRB_A_DEVTYPE 8'h00
`define LDRB_A_HWREV 8'h01
`define LDRB_A_FWHI 8'h02
`define LDRB_A_FWLO 8'h03
`define LDRB_A_SETUP 8'h04
`define LDRB_A_EXPO 8'h05
`define LDRB_A_TEMP 8'h06
`define LDRB_A_LAMP 8'h07
`define LDRB_A_EXTDEV 8'h4F
`define LDRB_A_DIRSET 8'h60
`define LDRB_A_DIRHS 8'h61
`define LDRB_A_CH1H 8'h62
`define LDRB_A_CH1L 8'h63
`define LDRB_A_CH2H 8'h64
`define LDRB_A_CH2L 8'h65
`define LDRB_A_CH3H 8'h66
`define LDRB_A_CH3L 8'h67
`define LDRB_A_LUXH 8'h70
`define LDRB_A_LUXL 8'h71

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LDRB_B_FAULT_RST 7
`define LDRB_B_GAIN_HI 5
`define LDRB_B_GAIN_LO 4
`define LDRB_B_RDY 1
`define LDRB_B_SOFT_RST 0
`define LDRB_B_MODE_HI 7
`define LDRB_B_MODE_LO 4
`define LDRB_B_INTEN 1
`define LDRB_B_LEARN 0
`define LDRB_B_START 0
`define LDRB_RST_EXPO 8'h14
`define LDRB_RST_LAMP 8'h01
`define LDRB_FWPOS_MAJOR 2'h1
`define LDRB_FWPOS_PATCH 2'h2
`define LDRB_FWPOS_BUILD 2'h3

// ****************************************************************
// Timing: integration step and soft reset length
// ****************************************************************
`define LDRB_STEP_NS 2800000
`define LDRB_CLK_NS 100
`define LDRB_STEP_CYC (`LDRB_STEP_NS / `LDRB_CLK_NS)
`define LDRB_SOFT_RST_CYC 16

`endif

//--- rtl/ldrb_pkg.sv
// Types shared by the register bank.
`default_nettype none
package ldrb_pkg;
   // Host register access from the serial slave engine.
   typedef struct packed {
      logic start;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ldrb_acc_t;

   // Director results from the director engine.
   typedef struct packed {
      logic valid;
      logic [15:0] ch1;
      logic [15:0] ch2;
      logic [15:0] ch3;
   } ldrb_res_t;

   typedef enum logic [1:0] {LDRB_IDLE, LDRB_RESET} ldrb_st_t;
endpackage
`default_nettype wire

//--- test/ldrb_host.sv
// Host-side partner model that issues register accesses to the bank.
`default_nettype none
module ldrb_host (
   input wire logic sys_clk,
   output var ldrb_pkg::ldrb_acc_t acc,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus idles from time zero so nothing lands during reset.
   initial acc = '0;
   // One write; with st clear the bank's own pointer picks the address.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic st);
      @(posedge sys_clk);
      acc <= '{start: st, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      acc <= '0;
      #1;
   endtask
   // One read; data is taken once the accepting edge has settled.
   task automatic rd(input logic [7:0] a, input logic st, output logic [7:0] d);
      @(posedge sys_clk);
      acc <= '{start: st, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      acc <= '0;
      #1;
      d = rdata;
   endtask
   // A new run is asked for only after the last one was handed back.
   task automatic go(output logic ok);
      logic [7:0] d;
      rd(8'h61, 1'b1, d);
      ok = (d[0] === 1'b0);
      if (ok)
         wr(8'h61, 8'h01, 1'b1);
   endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the lighting director register bank.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ******
   // Harness
   // ******
   localparam logic [7:0] DT = 8'h3C; // Arbitrary value.
   localparam logic [7:0] HR = 8'hC3; // Arbitrary value.
   localparam logic [47:0] FW = 48'h1234_5678_9ABC; // Arbitrary values.
   logic sys_clk = 1'b0, resetn = 1'b0, conv_done = 1'b0, gain_fault = 1'b0;
   logic [7:0] die_temp = 8'h5C, ext_status = 8'hA3, rdata, exposure;
   ldrb_pkg::ldrb_acc_t acc;
   ldrb_pkg::ldrb_res_t res = '0;
   logic [1:0] gain_sel;
   logic [3:0] mode;
   logic [15:0] lux_goal;
   logic integ_tick, rst_busy, learn_pulse, conv_start, int_out, lamp;
   int errors = 0, num_checks = 0, cyc = 0, learn_seen = 0;
   logic [31:0] seed = 32'h0001_1BA8;
   // A short step keeps the tick period visible in a brief run.
   ldrb_bank #(.DEV_TYPE(DT), .HW_REV(HR), .FW_MAJOR(FW[47:32]), .FW_PATCH(FW[31:16]),
      .FW_BUILD(FW[15:0]), .STEP_CYC(10)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .acc(acc), .rdata(rdata), .res(res), .conv_done(conv_done), .gain_fault(gain_fault),
      .die_temp(die_temp), .ext_status(ext_status), .gain_sel(gain_sel), .exposure(exposure),
      .integ_tick(integ_tick), .soft_reset_busy(rst_busy), .learn_pulse(learn_pulse),
      .channel_mode_select(mode), .lux_goal(lux_goal), .conv_start(conv_start),
      .int_out(int_out), .indicator_lamp_output(lamp));
   ldrb_host host (.sys_clk(sys_clk), .acc(acc), .rdata(rdata));
   // Clock, learn pulse counter and hang limit.
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (learn_pulse === 1'b1)
         learn_seen <= learn_seen + 1;
      if (cyc == 6000) begin
         errors++;
         final_report();
      end
   end
   // ******
   // Helpers
   // ******
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] fwv(int q);
      case (q)
         1: return FW[47:32];
         2: return FW[31:16];
         3: return FW[15:0];
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [7:0] rst_exp(int i);
      case (i)
         0: return DT;
         1: return HR;
         5: return 8'h14;
         6: return die_temp;
         7: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   // Channel 3 in mode 1 is the complement of channel 2's source.
   function automatic logic [15:0] chexp(int m, int c, logic [47:0] r);
      if (c == 0)
         return r[47:32];
      if (m == 0)
         return 16'h0000;
      if (c == 2 && m == 1)
         return ~r[31:16];
      return (c == 1) ? r[31:16] : r[15:0];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic st, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, st, d);
      chk(16'(d), 16'(exp), "read");
   endtask
   task automatic endt(input string n);
      $display("test %s finished", n);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ******
   // Scenarios
   // ******
   initial begin
      logic [7:0] d;
      logic [15:0] v;
      logic [47:0] r;
      logic ok;
      int t;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rc(8'h00, i == 0, rst_exp(i));
      rc(8'h70, 1'b1, 8'h00);
      rc(8'h62, 1'b1, 8'h00);
      host.wr(8'h00, ~DT, 1'b1);
      rc(8'h00, 1'b1, DT);
      endt("reset");
      for (int p = 0; p < 8; p++) begin
         host.wr(8'h02 + 8'(p & 1), 8'(p), 1'b1);
         v = fwv(p);
         rc(8'h02, 1'b1, v[15:8]);
         rc(8'h00, 1'b0, v[7:0]);
      end
      host.wr(8'h02, 8'h02, 1'b1);
      host.wr(8'h03, 8'h04 | 8'(rnd()), 1'b1);
      rc(8'h02, 1'b1, 8'h00);
      rc(8'h00, 1'b0, 8'h00);
      endt("firmware");
      for (int p = 0; p < 4; p++) begin
         d = (8'(rnd()) & 8'h4E) | 8'(p << 4);
         host.wr(8'h04, d, 1'b1);
         chk(16'(gain_sel), 16'(p), "gain");
         rc(8'h04, 1'b1, 8'(p << 4));
      end
      for (int p = 0; p < 2; p++) begin
         host.wr(8'h60, 8'(p << 1), 1'b1);
         @(posedge sys_clk) conv_done <= 1'b1;
         @(posedge sys_clk) conv_done <= 1'b0;
         #1;
         chk(16'(int_out), 16'(p), "int");
         host.rd(8'h04, 1'b1, d);
         chk(16'(d[1]), 16'h0001, "ready");
         chk(16'(int_out), 16'h0000, "int clear");
         rc(8'h04, 1'b1, 8'h30);
      end
      endt("setup");
      @(posedge sys_clk) gain_fault <= 1'b1;
      rc(8'h04, 1'b1, 8'hB0);
      @(posedge sys_clk) gain_fault <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         host.wr(8'h04, k ? 8'hB0 : 8'h31, 1'b1);
         chk(16'(rst_busy), 16'h0001, "busy");
         t = 0;
         if (k == 0) begin
            rc(8'h04, 1'b1, 8'h31);
            t = 2;
         end
         while (rst_busy === 1'b1 && t < 40) begin
            @(posedge sys_clk);
            #1;
            t++;
         end
         chk(16'(t), 16'h0010, "busy length");
         rc(8'h04, 1'b1, 8'h30);
      end
      endt("soft reset");
      for (int p = 0; p < 6; p++) begin
         d = (p == 0) ? 8'h01 : (p == 1) ? 8'hFF : 8'(rnd() % 255 + 1);
         host.wr(8'h05, d, 1'b1);
         chk(16'(exposure), 16'(d), "exposure");
         rc(8'h05, 1'b1, d);
      end
      for (int k = 0; k < 2; k++) begin
         t = 0;
         do begin
            @(posedge sys_clk);
            #1;
            t++;
         end while (integ_tick !== 1'b1 && t < 40);
      end
      chk(16'(t), 16'h000A, "tick");
      @(posedge sys_clk) die_temp <= 8'(rnd());
      @(posedge sys_clk) ext_status <= 8'(rnd());
      host.wr(8'h06, 8'hFF, 1'b1);
      rc(8'h06, 1'b1, die_temp);
      rc(8'h4F, 1'b1, ext_status);
      rc(8'h80, 1'b1, 8'h00);
      endt("sensor");
      for (int p = 0; p < 3; p++) begin
         host.wr(8'h60, {4'(p), 4'h1}, 1'b1);
         chk(16'(mode), 16'(p), "mode");
         rc(8'h60, 1'b1, {4'(p), 4'h0});
         chk(16'(learn_seen), 16'(p + 1), "learn");
         host.go(ok);
         chk(16'(ok & conv_start), 16'h0001, "start");
         r = {16'(rnd()), 16'(rnd()), 16'(rnd())};
         @(posedge sys_clk) res <= '{valid: 1'b1, ch1: r[47:32], ch2: r[31:16], ch3: r[15:0]};
         @(posedge sys_clk) res <= '0;
         rc(8'h61, 1'b1, 8'h00);
         for (int i = 0; i < 6; i++) begin
            v = chexp(p, i / 2, r);
            rc(8'h62, i == 0, (i % 2) ? v[7:0] : v[15:8]);
         end
      end
      endt("director");
      v = 16'(rnd());
      host.wr(8'h70, v[15:8], 1'b1);
      host.wr(8'h8F, v[7:0], 1'b0);
      chk(lux_goal, v, "lux");
      rc(8'h70, 1'b1, v[15:8]);
      rc(8'h00, 1'b0, v[7:0]);
      host.wr(8'h07, 8'h00, 1'b1);
      chk(16'(lamp), 16'h0000, "lamp");
      // A second reset in mid-run, with a run pending and the flag set.
      host.go(ok);
      @(posedge sys_clk) conv_done <= 1'b1;
      @(posedge sys_clk) conv_done <= 1'b0;
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      chk(16'(conv_start), 16'h0000, "start reset");
      chk(lux_goal, 16'h0000, "lux reset");
      chk(16'(lamp), 16'h0001, "lamp reset");
      rc(8'h04, 1'b1, 8'h00);
      endt("lux and reset");
      final_report();
   end
endmodule
`default_nettype wire
